// file: rtl/ssl_pkg.sv
// constants and types shared by the serial latch loader
package ssl_pkg;

    // ****************************************
    // shift word and latch select
    // ****************************************
    localparam int WORD_W = 24;
    localparam int SEL_LSB = 0;
    localparam int SEL_W = 2;
    localparam logic [1:0] SEL_REF = 2'h0;
    localparam logic [1:0] SEL_FB = 2'h1;
    localparam logic [1:0] SEL_FUNC = 2'h2;
    localparam logic [1:0] SEL_INIT = 2'h3;
    localparam logic [23:0] LATCH_RST = 24'h000000;

    // ****************************************
    // reference divider latch fields
    // ****************************************
    localparam int RDIV_LSB = 2;
    localparam int RDIV_W = 14;
    localparam int ABP_LSB = 16;
    localparam int ABP_W = 2;
    localparam int TEST_LSB = 18;
    localparam int TEST_W = 2;
    localparam int LDP_BIT = 20;

    // ****************************************
    // feedback divider latch fields
    // ****************************************
    localparam int SWAL_LSB = 2;
    localparam int SWAL_W = 6;
    localparam int MAIN_LSB = 8;
    localparam int MAIN_W = 13;
    localparam int GAIN_BIT = 21;
    localparam int FBCNT_W = 20;

    // ****************************************
    // function / initialization latch fields
    // ****************************************
    localparam int CNTRST_BIT = 2;
    localparam int PD1_BIT = 3;
    localparam int MUX_LSB = 4;
    localparam int MUX_W = 3;
    localparam int PD2_BIT = 21;
    localparam int PRESC_LSB = 22;
    localparam int PRESC_W = 2;
    localparam int PRESC_BASE_SHIFT = 3;

    // ****************************************
    // output select codes
    // ****************************************
    localparam logic [2:0] MUX_TRISTATE = 3'h0;
    localparam logic [2:0] MUX_DLOCK = 3'h1;
    localparam logic [2:0] MUX_FBDIV = 3'h2;
    localparam logic [2:0] MUX_HIGH = 3'h3;
    localparam logic [2:0] MUX_REFDIV = 3'h4;
    localparam logic [2:0] MUX_ALOCK = 3'h5;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_NS = 50;
    localparam int LOCK_ERR_NS = 15;
    localparam int UNLOCK_ERR_NS = 25;
    // phase error is measured in whole clock cycles
    localparam int LOCK_ERR_CYC = (LOCK_ERR_NS + CLK_NS - 1) / CLK_NS;
    localparam int UNLOCK_ERR_CYC = UNLOCK_ERR_NS / CLK_NS;
    localparam logic [2:0] LOCK_CNT_LO = 3'h3;
    localparam logic [2:0] LOCK_CNT_HI = 3'h5;

    typedef enum logic [1:0] {
        PFD_IDLE = 2'b00,
        PFD_UP = 2'b01,
        PFD_DN = 2'b10,
        PFD_RST = 2'b11
    } ssl_pfd_t;

endpackage

// file: rtl/ssl_shift_in.sv
// serial shift register on the link clock
`timescale 1ns/1ps
module ssl_shift_in (
    input wire logic sclk, // serial clock from the host
    input wire logic sdata, // serial data, valid at sclk rise
    output logic [23:0] shift_word // current shift register contents
);

    typedef struct packed {
        logic [23:0] word;
    } ssl_shift_t;

    ssl_shift_t st_r;
    ssl_shift_t st_nxt;

    // ****************************************
    // shifter
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.word = {st_r.word[22:0], sdata};
    end

    // pure data path, so no reset is needed here
    always_ff @(posedge sclk) begin
        st_r <= st_nxt;
    end

    assign shift_word = st_r.word;

    // no reset on this register, so only judge it once a full word has filled it
    property p_shift;
        @(posedge sclk) 1'b1 ##23 1'b1 |=> (shift_word[0] == $past(sdata))
            && (shift_word[23:1] == $past(shift_word[22:0]));
    endproperty
    a_shift: assert property (p_shift) else $error("shift register did not take serial bit");

endmodule // ssl_shift_in

// file: rtl/ssl_loader.sv
// serial latch loader, phase detector and lock indication
`timescale 1ns/1ps
module ssl_loader #(
    parameter int ERR_W = 8
) (
    input wire logic mclk, // system clock
    input wire logic rst, // synchronous reset, active high
    input wire logic cen, // clock enable, freezes state when low
    input wire logic sclk, // serial clock pin
    input wire logic sdata, // serial data pin
    input wire logic load_strobe, // load strobe pin
    input wire logic chip_enable, // chip enable pin, low disables
    input wire logic ref_in, // reference input pin
    input wire logic fb_in, // prescaler output to feedback divider
    output logic mux_output_pin_o, // output pin level
    output logic mux_output_pin_oe, // output pin drive enable
    output logic pump_up, // phase detector up pulse
    output logic pump_dn, // phase detector down pulse
    output logic digital_lock, // digital lock indicator
    output logic pump_gain_select, // pump gain from feedback latch
    output logic [1:0] test_bits, // test bits from reference latch
    output logic powered_down // programmed power-down in effect, stays low while only chip enable holds the device down
);

    typedef struct packed {
        logic le_s1;
        logic le_s2;
        logic le_d;
        logic ce_s1;
        logic ce_s2;
        logic ref_s1;
        logic ref_s2;
        logic ref_d;
        logic fb_s1;
        logic fb_s2;
        logic fb_d;
        logic [23:0] ref_latch;
        logic [23:0] fb_latch;
        logic [23:0] func_latch;
        logic [23:0] init_latch;
        logic [23:0] cfg;
        logic [13:0] ref_cnt;
        logic [19:0] fb_cnt;
        logic ref_tick;
        logic fb_tick;
        ssl_pkg::ssl_pfd_t pfd;
        logic [1:0] adz_cnt;
        logic [ERR_W-1:0] err_cnt;
        logic [2:0] good_cnt;
        logic lock;
        logic pd;
        logic pump_up;
        logic pump_dn;
        logic mux_out;
        logic mux_oe;
    } ssl_state_t;

    ssl_state_t st_r;
    ssl_state_t st_nxt;
    logic [23:0] shift_word;
    logic le_rise;
    logic ref_rise;
    logic fb_rise;
    logic halt;
    logic div_clr;
    logic ev;
    logic [ERR_W-1:0] ev_err;
    logic [13:0] rdiv;
    logic [19:0] ntot;
    logic [2:0] need;
    logic [1:0] abp;
    logic [2:0] mux_sel;

    function automatic logic rose(input logic now, input logic prev);
        return now && !prev;
    endfunction

    function automatic logic [ERR_W-1:0] sat_inc(input logic [ERR_W-1:0] v);
        return (&v) ? v : ERR_W'(v + 1'b1);
    endfunction

    // ****************************************
    // link side shift register
    // ****************************************
    ssl_shift_in u_shift (
        .sclk(sclk),
        .sdata(sdata),
        .shift_word(shift_word)
    );

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        // pin synchronisers
        st_nxt.le_s1 = load_strobe;
        st_nxt.le_s2 = st_r.le_s1;
        st_nxt.le_d = st_r.le_s2;
        st_nxt.ce_s1 = chip_enable;
        st_nxt.ce_s2 = st_r.ce_s1;
        st_nxt.ref_s1 = ref_in;
        st_nxt.ref_s2 = st_r.ref_s1;
        st_nxt.ref_d = st_r.ref_s2;
        st_nxt.fb_s1 = fb_in;
        st_nxt.fb_s2 = st_r.fb_s1;
        st_nxt.fb_d = st_r.fb_s2;
        le_rise = rose(st_r.le_s2, st_r.le_d);
        ref_rise = rose(st_r.ref_s2, st_r.ref_d);
        fb_rise = rose(st_r.fb_s2, st_r.fb_d);

        // the host keeps sclk still while the strobe is high, so the word is stable when sampled
        if (le_rise) begin
            unique case (shift_word[ssl_pkg::SEL_LSB +: ssl_pkg::SEL_W])
                ssl_pkg::SEL_REF: st_nxt.ref_latch = shift_word;
                ssl_pkg::SEL_FB: st_nxt.fb_latch = shift_word;
                ssl_pkg::SEL_FUNC: begin
                    st_nxt.func_latch = shift_word;
                    st_nxt.cfg = shift_word;
                end
                ssl_pkg::SEL_INIT: begin
                    st_nxt.init_latch = shift_word;
                    st_nxt.cfg = shift_word;
                end
            endcase
        end

        // power state
        halt = !st_r.ce_s2 || st_r.pd;
        div_clr = halt || st_r.cfg[ssl_pkg::CNTRST_BIT];

        // reference divider
        rdiv = st_r.ref_latch[ssl_pkg::RDIV_LSB +: ssl_pkg::RDIV_W];
        st_nxt.ref_tick = 1'b0;
        if (div_clr) begin
            st_nxt.ref_cnt = 14'h0000;
        end else if (ref_rise) begin
            if (14'(st_r.ref_cnt + 14'h0001) >= rdiv) begin
                st_nxt.ref_cnt = 14'h0000;
                st_nxt.ref_tick = 1'b1;
            end else begin
                st_nxt.ref_cnt = 14'(st_r.ref_cnt + 14'h0001);
            end
        end

        // feedback divider, total ratio main * prescale + swallow
        ntot = 20'((20'(st_r.fb_latch[ssl_pkg::MAIN_LSB +: ssl_pkg::MAIN_W])
            << (ssl_pkg::PRESC_BASE_SHIFT + st_r.cfg[ssl_pkg::PRESC_LSB +: ssl_pkg::PRESC_W]))
            + 20'(st_r.fb_latch[ssl_pkg::SWAL_LSB +: ssl_pkg::SWAL_W]));
        st_nxt.fb_tick = 1'b0;
        if (div_clr) begin
            st_nxt.fb_cnt = 20'h00000;
        end else if (fb_rise) begin
            if (20'(st_r.fb_cnt + 20'h00001) >= ntot) begin
                st_nxt.fb_cnt = 20'h00000;
                st_nxt.fb_tick = 1'b1;
            end else begin
                st_nxt.fb_cnt = 20'(st_r.fb_cnt + 20'h00001);
            end
        end

        // phase detector; ticks arriving during the reset phase are dropped
        abp = st_r.ref_latch[ssl_pkg::ABP_LSB +: ssl_pkg::ABP_W];
        ev = 1'b0;
        ev_err = st_r.err_cnt;
        if (div_clr) begin
            st_nxt.pfd = ssl_pkg::PFD_IDLE;
            st_nxt.err_cnt = '0;
            st_nxt.adz_cnt = 2'h0;
        end else begin
            unique case (st_r.pfd)
                ssl_pkg::PFD_IDLE: begin
                    if (st_r.ref_tick && st_r.fb_tick) begin
                        st_nxt.pfd = ssl_pkg::PFD_RST;
                        st_nxt.adz_cnt = 2'h0;
                        ev = 1'b1;
                        ev_err = '0;
                    end else if (st_r.ref_tick) begin
                        st_nxt.pfd = ssl_pkg::PFD_UP;
                        st_nxt.err_cnt = ERR_W'(1);
                    end else if (st_r.fb_tick) begin
                        st_nxt.pfd = ssl_pkg::PFD_DN;
                        st_nxt.err_cnt = ERR_W'(1);
                    end
                end
                ssl_pkg::PFD_UP: begin
                    if (st_r.fb_tick) begin
                        st_nxt.pfd = ssl_pkg::PFD_RST;
                        st_nxt.adz_cnt = 2'h0;
                        ev = 1'b1;
                    end else begin
                        st_nxt.err_cnt = sat_inc(st_r.err_cnt);
                    end
                end
                ssl_pkg::PFD_DN: begin
                    if (st_r.ref_tick) begin
                        st_nxt.pfd = ssl_pkg::PFD_RST;
                        st_nxt.adz_cnt = 2'h0;
                        ev = 1'b1;
                    end else begin
                        st_nxt.err_cnt = sat_inc(st_r.err_cnt);
                    end
                end
                ssl_pkg::PFD_RST: begin
                    // both pumps stay on for pulse width setting + 1 cycles
                    if (st_r.adz_cnt == abp) begin
                        st_nxt.pfd = ssl_pkg::PFD_IDLE;
                        st_nxt.err_cnt = '0;
                    end else begin
                        st_nxt.adz_cnt = 2'(st_r.adz_cnt + 2'h1);
                    end
                end
            endcase
        end
        st_nxt.pump_up = !div_clr && (st_nxt.pfd == ssl_pkg::PFD_UP || st_nxt.pfd == ssl_pkg::PFD_RST);
        st_nxt.pump_dn = !div_clr && (st_nxt.pfd == ssl_pkg::PFD_DN || st_nxt.pfd == ssl_pkg::PFD_RST);

        // digital lock detector
        need = st_r.ref_latch[ssl_pkg::LDP_BIT] ? ssl_pkg::LOCK_CNT_HI : ssl_pkg::LOCK_CNT_LO;
        if (halt) begin
            st_nxt.lock = 1'b0;
            st_nxt.good_cnt = 3'h0;
        end else if (ev) begin
            if (32'(ev_err) < ssl_pkg::LOCK_ERR_CYC) begin
                st_nxt.good_cnt = (st_r.good_cnt == 3'h7) ? 3'h7 : 3'(st_r.good_cnt + 3'h1);
                if (3'(st_r.good_cnt + 3'h1) >= need) begin
                    st_nxt.lock = 1'b1;
                end
            end else begin
                st_nxt.good_cnt = 3'h0;
            end
            if (32'(ev_err) > ssl_pkg::UNLOCK_ERR_CYC) begin
                st_nxt.lock = 1'b0;
            end
        end

        // programmed power-down: immediate, or at next pump event
        if (!st_r.cfg[ssl_pkg::PD1_BIT]) begin
            st_nxt.pd = 1'b0;
        end else if (!st_r.cfg[ssl_pkg::PD2_BIT] || ev) begin
            st_nxt.pd = 1'b1;
        end

        // output multiplexer
        mux_sel = st_r.cfg[ssl_pkg::MUX_LSB +: ssl_pkg::MUX_W];
        st_nxt.mux_oe = 1'b1;
        st_nxt.mux_out = 1'b0;
        if (!st_r.ce_s2) begin
            st_nxt.mux_oe = 1'b0;
        end else begin
            unique case (mux_sel)
                ssl_pkg::MUX_TRISTATE: st_nxt.mux_oe = 1'b0;
                ssl_pkg::MUX_DLOCK: st_nxt.mux_out = st_r.lock;
                ssl_pkg::MUX_FBDIV: st_nxt.mux_out = st_r.fb_tick;
                ssl_pkg::MUX_HIGH: st_nxt.mux_out = 1'b1;
                ssl_pkg::MUX_REFDIV: st_nxt.mux_out = st_r.ref_tick;
                ssl_pkg::MUX_ALOCK: st_nxt.mux_oe = st_r.pump_up ^ st_r.pump_dn;
                default: st_nxt.mux_out = 1'b0;
            endcase
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_r <= '0;
        end else if (cen) begin
            st_r <= st_nxt;
        end
    end

    assign mux_output_pin_o = st_r.mux_out;
    assign mux_output_pin_oe = st_r.mux_oe;
    assign pump_up = st_r.pump_up;
    assign pump_dn = st_r.pump_dn;
    assign digital_lock = st_r.lock;
    assign pump_gain_select = st_r.fb_latch[ssl_pkg::GAIN_BIT];
    assign test_bits = st_r.ref_latch[ssl_pkg::TEST_LSB +: ssl_pkg::TEST_W];
    assign powered_down = st_r.pd;

    // ****************************************
    // assertions
    // ****************************************
    property p_load_ref;
        @(posedge mclk) disable iff (rst)
        (cen && le_rise && shift_word[1:0] == ssl_pkg::SEL_REF) |=> st_r.ref_latch == $past(shift_word);
    endproperty
    a_load_ref: assert property (p_load_ref) else $error("reference latch not loaded");

    property p_load_fb;
        @(posedge mclk) disable iff (rst)
        (cen && le_rise && shift_word[1:0] == ssl_pkg::SEL_FB) |=> st_r.fb_latch == $past(shift_word)
            && $stable(st_r.ref_latch) && $stable(st_r.func_latch) && $stable(st_r.init_latch);
    endproperty
    a_load_fb: assert property (p_load_fb) else $error("feedback load disturbed other latch");

    property p_keep;
        @(posedge mclk) disable iff (rst)
        (cen && !le_rise) |=> $stable(st_r.ref_latch) && $stable(st_r.fb_latch)
            && $stable(st_r.func_latch) && $stable(st_r.init_latch);
    endproperty
    a_keep: assert property (p_keep) else $error("latch changed without load strobe");

    property p_lock3;
        @(posedge mclk) disable iff (rst)
        ($rose(digital_lock) && !$past(st_r.ref_latch[ssl_pkg::LDP_BIT])) |-> $past(st_r.good_cnt) >= 3'h2;
    endproperty
    a_lock3: assert property (p_lock3) else $error("lock set before three good cycles");

    property p_lock5;
        @(posedge mclk) disable iff (rst)
        ($rose(digital_lock) && $past(st_r.ref_latch[ssl_pkg::LDP_BIT])) |-> $past(st_r.good_cnt) >= 3'h4;
    endproperty
    a_lock5: assert property (p_lock5) else $error("lock set before five good cycles");

    property p_unlock;
        @(posedge mclk) disable iff (rst)
        (cen && ev && 32'(ev_err) > ssl_pkg::UNLOCK_ERR_CYC) |=> !digital_lock;
    endproperty
    a_unlock: assert property (p_unlock) else $error("lock kept after large phase error");

    property p_adz;
        @(posedge mclk) disable iff (rst)
        (cen && !div_clr && st_r.pfd == ssl_pkg::PFD_RST && st_r.adz_cnt < abp) |=> pump_up && pump_dn;
    endproperty
    a_adz: assert property (p_adz) else $error("anti-deadzone pulse ended early");

    property p_pfd_up;
        @(posedge mclk) disable iff (rst)
        (cen && !div_clr && st_r.pfd == ssl_pkg::PFD_IDLE && st_r.ref_tick && !st_r.fb_tick) |=> pump_up && !pump_dn;
    endproperty
    a_pfd_up: assert property (p_pfd_up) else $error("reference lead gave no up pulse");

    property p_cnt_rst;
        @(posedge mclk) disable iff (rst)
        (cen && st_r.cfg[ssl_pkg::CNTRST_BIT]) |=> st_r.ref_cnt == 14'h0000 && st_r.fb_cnt == 20'h00000;
    endproperty
    a_cnt_rst: assert property (p_cnt_rst) else $error("dividers ran during divider reset");

    property p_ce_off;
        @(posedge mclk) disable iff (rst)
        (cen && !st_r.ce_s2) |=> !mux_output_pin_oe && !pump_up && !pump_dn && !digital_lock;
    endproperty
    a_ce_off: assert property (p_ce_off) else $error("device active with chip enable low");

    property p_mux_dlock;
        @(posedge mclk) disable iff (rst)
        (cen && st_r.ce_s2 && mux_sel == ssl_pkg::MUX_DLOCK) |=> mux_output_pin_oe
            && mux_output_pin_o == $past(st_r.lock);
    endproperty
    a_mux_dlock: assert property (p_mux_dlock) else $error("output pin does not show lock");

    property p_alock;
        @(posedge mclk) disable iff (rst)
        (cen && st_r.ce_s2 && mux_sel == ssl_pkg::MUX_ALOCK) |=> !mux_output_pin_o
            && mux_output_pin_oe == ($past(st_r.pump_up) ^ $past(st_r.pump_dn));
    endproperty
    a_alock: assert property (p_alock) else $error("open drain lock output wrong");

    c_lock: cover property (@(posedge mclk) disable iff (rst) $rose(digital_lock));
    c_init: cover property (@(posedge mclk) disable iff (rst) le_rise && shift_word[1:0] == ssl_pkg::SEL_INIT);
    c_alock: cover property (@(posedge mclk) disable iff (rst) mux_sel == ssl_pkg::MUX_ALOCK && mux_output_pin_oe);

endmodule // ssl_loader

// file: test/ssl_host_model.sv
// host model driving the three-wire programming link
`timescale 1ns/1ps
module ssl_host_model (
    output logic sclk, // serial clock, idle low
    output logic sdata, // serial data
    output logic load_strobe // load strobe
);
    initial begin
        sclk = 1'b0;
        sdata = 1'b0;
        load_strobe = 1'b0;
    end
    // ****************************************
    // one frame, 64 ns link clock
    // ****************************************
    task automatic send(input logic [23:0] word, input logic strobe);
        for (int i = 23; i >= 0; i--) begin
            sdata = word[i];
            #32 sclk = 1'b1;
            #32 sclk = 1'b0;
        end
        // released line must not show the last bit
        sdata = ~sdata;
        if (strobe) begin
            #100 load_strobe = 1'b1;
            #300 load_strobe = 1'b0;
        end
        #300;
    endtask
endmodule // ssl_host_model

// file: test/tb_ssl_loader.sv
// self-checking bench for the serial latch loader
`timescale 1ns/1ps
module tb_ssl_loader;
    logic mclk, rst, chip_enable, ref_in, fb_in, probe;
    logic sclk, sdata, load_strobe, mux_o, mux_oe, pump_up, pump_dn, dlock, gain, pd;
    logic [1:0] tbits;
    logic [1:0] t;
    logic g;
    logic [8:0] exp_q[$];
    int fails = 0;
    int n_checks = 0;
    int cyc = 0;

    ssl_host_model host (.sclk(sclk), .sdata(sdata), .load_strobe(load_strobe));
    ssl_loader dut (.mclk(mclk), .rst(rst), .cen(1'b1), .sclk(sclk), .sdata(sdata),
        .load_strobe(load_strobe), .chip_enable(chip_enable), .ref_in(ref_in), .fb_in(fb_in),
        .mux_output_pin_o(mux_o), .mux_output_pin_oe(mux_oe), .pump_up(pump_up), .pump_dn(pump_dn),
        .digital_lock(dlock), .pump_gain_select(gain), .test_bits(tbits), .powered_down(pd));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // ****************************************
    // checking and closing
    // ****************************************
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // monitor samples at the falling edge, where outputs are settled
    always @(negedge mclk) if (probe === 1'b1) check({tbits, gain, mux_o, mux_oe, dlock, pump_up, pump_dn, pd}, exp_q.pop_front());

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 6000) begin
            fails++;
            end_of_test();
        end
    end

    // ****************************************
    // stimulus helpers
    // ****************************************
    task automatic expect_obs(input logic [8:0] v);
        @(posedge mclk);
        exp_q.push_back(v);
        probe <= 1'b1;
        @(posedge mclk);
        probe <= 1'b0;
    endtask

    // pump up, pump down and power-down sit in the low three bits
    function automatic logic [8:0] e(input logic o, input logic oe, input logic l);
        return {t, g, o, oe, l, 3'h0};
    endfunction

    // pulse width code 2, not the smallest
    function automatic logic [23:0] refw(input logic lock_precision_sel);
        return {1'b0, 2'h0, lock_precision_sel, t, 2'h2, 14'h0008, ssl_pkg::SEL_REF};
    endfunction

    function automatic logic [23:0] cfg(input logic [2:0] mux, input logic rbit, input logic [1:0] sel);
        return {2'h0, 1'b0, 14'h0000, mux, 1'b0, rbit, sel};
    endfunction

    // equal divide ratios of 8: one detector cycle per 8 pulses
    task automatic pulses(input int n, input logic r, input logic f);
        repeat (n) begin
            @(negedge mclk);
            ref_in = r;
            fb_in = f;
            repeat (2) @(negedge mclk);
            ref_in = 1'b0;
            fb_in = 1'b0;
            @(negedge mclk);
        end
        repeat (6) @(negedge mclk);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rst = 1'b1;
        chip_enable = 1'b1;
        ref_in = 1'b0;
        fb_in = 1'b0;
        probe = 1'b0;
        void'($urandom(32'h3f60));
        {t, g} = 3'($urandom);
        repeat (6) @(negedge mclk);
        rst = 1'b0;
        repeat (4) @(negedge mclk);
        host.send({t, g, 21'h1FFFFF}, 1'b0);
        expect_obs(9'h000);
        host.send(refw(1'b0), 1'b1);
        expect_obs({t, 7'h00});
        host.send({2'h0, g, 13'h0001, 6'h00, ssl_pkg::SEL_FB}, 1'b1);
        expect_obs(e(1'b0, 1'b0, 1'b0));
        host.send(cfg(3'h3, 1'b0, ssl_pkg::SEL_FUNC), 1'b1);
        expect_obs(e(1'b1, 1'b1, 1'b0));
        host.send(cfg(3'h6, 1'b0, ssl_pkg::SEL_INIT), 1'b1);
        expect_obs(e(1'b0, 1'b1, 1'b0));
        host.send(cfg(3'h1, 1'b0, ssl_pkg::SEL_FUNC), 1'b1);
        pulses(20, 1'b1, 1'b1);
        expect_obs(e(1'b0, 1'b1, 1'b0));
        pulses(8, 1'b1, 1'b1);
        expect_obs(e(1'b1, 1'b1, 1'b1));
        // reference leads: its divider wraps four pulses before the feedback one
        pulses(4, 1'b1, 1'b0);
        expect_obs(e(1'b1, 1'b1, 1'b1) | 9'h004);
        host.send(cfg(3'h5, 1'b0, ssl_pkg::SEL_FUNC), 1'b1);
        expect_obs(e(1'b0, 1'b1, 1'b1) | 9'h004);
        host.send(cfg(3'h1, 1'b0, ssl_pkg::SEL_FUNC), 1'b1);
        pulses(4, 1'b1, 1'b1);
        expect_obs(e(1'b0, 1'b1, 1'b0));
        host.send(refw(1'b1), 1'b1);
        host.send(cfg(3'h1, 1'b1, ssl_pkg::SEL_FUNC), 1'b1);
        pulses(44, 1'b1, 1'b1);
        expect_obs(e(1'b0, 1'b1, 1'b0));
        host.send(cfg(3'h1, 1'b0, ssl_pkg::SEL_FUNC), 1'b1);
        pulses(36, 1'b1, 1'b1);
        expect_obs(e(1'b0, 1'b1, 1'b0));
        pulses(8, 1'b1, 1'b1);
        expect_obs(e(1'b1, 1'b1, 1'b1));
        // immediate programmed power-down drops the lock
        host.send(cfg(3'h1, 1'b0, ssl_pkg::SEL_FUNC) | 24'h000008, 1'b1);
        expect_obs(e(1'b0, 1'b1, 1'b0) | 9'h001);
        @(negedge mclk);
        chip_enable = 1'b0;
        repeat (6) @(negedge mclk);
        expect_obs(e(1'b0, 1'b0, 1'b0) | 9'h001);
        repeat (2) @(negedge mclk);
        end_of_test();
    end
endmodule // tb_ssl_loader
